// ===== common/fcs_pkg.sv
// Purpose: shared constants and types for the flash command host controller
// Assumes: 16-bit flash data bus, word addressing, 200 MHz mclk
// Notes: the command codes below are the flash's published bus cycles
package fcs_pkg;
	// ---------------------------------------------------------------
	// bus widths and timing
	// ---------------------------------------------------------------
	localparam int FCS_AW = 26;
	localparam int FCS_DW = 16;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_STROBE_NS = 60; // write/read strobe low time
	localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_SETUP_NS = 20; // address setup before strobe
	localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_STATUS_US = 4; // status bits valid only after this
	localparam int STATUS_CYC = (T_STATUS_US * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_POLL_LIMIT_US = 100000; // host give-up time
	// cycles per microsecond first, so the product stays inside an int
	localparam int POLL_LIMIT_CYC = T_POLL_LIMIT_US
		* (1000000 / CLK_PERIOD_PS);
	localparam int CNT_W = 32;
	// ---------------------------------------------------------------
	// unlock and command codes
	// ---------------------------------------------------------------
	localparam logic [FCS_AW-1:0] ADDR_UNLOCK1 = 26'h0000aaa;
	localparam logic [FCS_AW-1:0] ADDR_UNLOCK2 = 26'h0000555;
	localparam logic [7:0] DATA_UNLOCK1 = 8'haa;
	localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_EXIT2 = 8'h00;
	localparam int DQ_POLL = 7;
	localparam int DQ_TIMEOUT = 5;
	localparam int PWD_WORDS = 8;
	// ---------------------------------------------------------------
	// carriers and states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_PROGRAM = 3'h0, // unlock, a0, address/data, poll
		OP_RESET = 3'h1, // one f0 cycle
		OP_EXIT = 3'h2, // 90 then 00 leaves a protection set
		OP_WRITE = 3'h3, // single raw write cycle
		OP_READ = 3'h4 // single raw read cycle
	} fcs_op_t;
	typedef struct packed {
		fcs_op_t op;
		logic [FCS_AW-1:0] addr;
		logic [FCS_DW-1:0] data;
	} fcs_req_t;
	typedef struct packed {
		logic [FCS_DW-1:0] data;
		logic timeout;
		logic busy_seen;
	} fcs_rsp_t;
	typedef struct packed {
		logic [FCS_AW-1:0] addr;
		logic [FCS_DW-1:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic we_n;
		logic oe_n;
	} fcs_pins_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SETUP = 4'h1,
		ST_STROBE = 4'h3,
		ST_HOLD = 4'h2,
		ST_NEXT = 4'h6,
		ST_WAIT = 4'h7,
		ST_POLL = 4'h5,
		ST_DONE = 4'h4,
		ST_RECOVER = 4'hc
	} fcs_state_t;
endpackage : fcs_pkg

// ===== core/fcs_host.sv
// Purpose: host controller that drives a parallel NOR flash bus cycles
// Assumes: pins sampled through two flops, one request at a time
// Notes: program waits for polling to finish; timeout reported to user
`timescale 1ns/1ps
module fcs_host
	import fcs_pkg::*;
#(
	parameter int POLL_LIMIT = POLL_LIMIT_CYC
) (
	// clock, reset and enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// user request side
	input wire logic req_valid,
	output logic req_ready,
	input wire fcs_pkg::fcs_req_t req,
	// user answer side
	output logic rsp_valid,
	output fcs_pkg::fcs_rsp_t rsp,
	// flash pins; the data bus is split into in, out and enable
	output fcs_pkg::fcs_pins_t pins,
	input wire logic [fcs_pkg::FCS_DW-1:0] dq_in,
	input wire logic ready_busy_n
);
	import fcs_pkg::*;

	logic [FCS_DW-1:0] dq_s;
	logic ryby_s;
	fcs_state_t st_reg, st_next;
	fcs_req_t cur_reg, cur_next;
	fcs_pins_t pins_next;
	fcs_rsp_t rsp_next;
	logic rsp_valid_next;
	logic [2:0] step_reg, step_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] poll_reg, poll_next;
	logic cyc_rd;
	logic [FCS_AW-1:0] cyc_addr;
	logic [FCS_DW-1:0] cyc_data;
	logic last_step;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	fcs_sync #(.W(FCS_DW + 1)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.d({dq_in, ready_busy_n}),
		.q({dq_s, ryby_s})
	);

	// ---------------------------------------------------------------
	// cycle table
	// ---------------------------------------------------------------
	// address and data of the current bus cycle; commands carry only a
	// low byte, the high byte is left zero since the flash ignores it
	always_comb begin
		cyc_rd = 1'b0;
		cyc_addr = ADDR_UNLOCK1;
		cyc_data = '0;
		last_step = 1'b1;
		case (cur_reg.op)
			OP_PROGRAM: begin
				last_step = (step_reg == 3'h3);
				case (step_reg)
					3'h0: cyc_data = {8'h00, DATA_UNLOCK1};
					3'h1: begin
						cyc_addr = ADDR_UNLOCK2;
						cyc_data = {8'h00, DATA_UNLOCK2};
					end
					3'h2: cyc_data = {8'h00, CMD_PROGRAM};
					default: begin
						cyc_addr = cur_reg.addr;
						cyc_data = cur_reg.data;
					end
				endcase
			end
			OP_RESET: cyc_data = {8'h00, CMD_RESET};
			OP_EXIT: begin
				last_step = (step_reg == 3'h1);
				cyc_data = {8'h00, (step_reg == 3'h0) ? CMD_EXIT1 :
					CMD_EXIT2};
			end
			OP_WRITE: begin
				cyc_addr = cur_reg.addr;
				cyc_data = cur_reg.data;
			end
			OP_READ: begin
				cyc_rd = 1'b1;
				cyc_addr = cur_reg.addr;
			end
			default: cyc_data = '0;
		endcase
	end

	// ---------------------------------------------------------------
	// bus cycle sequencer
	// ---------------------------------------------------------------
	// one strobe per step; address is set before the strobe falls and
	// data held past its rise so either latch edge sees stable values
	always_comb begin
		st_next = st_reg;
		cur_next = cur_reg;
		step_next = step_reg;
		cnt_next = cnt_reg;
		poll_next = poll_reg;
		pins_next = pins;
		rsp_next = rsp;
		rsp_valid_next = 1'b0;
		case (st_reg)
			ST_IDLE: begin
				pins_next.ce_n = 1'b1;
				pins_next.we_n = 1'b1;
				pins_next.oe_n = 1'b1;
				pins_next.dq_oe = 1'b0;
				if (req_valid) begin
					cur_next = req;
					step_next = 3'h0;
					rsp_next = '0;
					st_next = ST_SETUP;
					cnt_next = '0;
				end
			end
			ST_SETUP: begin
				pins_next.addr = cyc_addr;
				pins_next.dq_out = cyc_data;
				pins_next.dq_oe = ~cyc_rd;
				pins_next.ce_n = 1'b0;
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg >= CNT_W'(SETUP_CYC - 1)) begin
					cnt_next = '0;
					st_next = ST_STROBE;
				end
			end
			ST_STROBE: begin
				pins_next.we_n = cyc_rd;
				pins_next.oe_n = ~cyc_rd;
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg >= CNT_W'(STROBE_CYC + 2)) begin
					cnt_next = '0;
					st_next = ST_HOLD;
					if (cyc_rd)
						rsp_next.data = dq_s;
				end
			end
			ST_HOLD: begin
				pins_next.we_n = 1'b1;
				pins_next.oe_n = 1'b1;
				st_next = ST_NEXT;
			end
			ST_NEXT: begin
				pins_next.ce_n = 1'b1;
				pins_next.dq_oe = 1'b0;
				if (!last_step) begin
					step_next = step_reg + 3'h1;
					st_next = ST_SETUP;
				end else if (cur_reg.op == OP_PROGRAM) begin
					st_next = ST_WAIT;
					poll_next = '0;
				end else begin
					st_next = ST_DONE;
				end
			end
			ST_WAIT: begin
				poll_next = poll_reg + 1'b1;
				if (!ryby_s)
					rsp_next.busy_seen = 1'b1;
				if (poll_reg >= CNT_W'(STATUS_CYC - 1)) begin
					st_next = ST_POLL;
					cnt_next = '0;
				end
			end
			ST_POLL: begin
				pins_next.addr = cur_reg.addr;
				pins_next.ce_n = 1'b0;
				pins_next.oe_n = 1'b0;
				pins_next.dq_oe = 1'b0;
				poll_next = poll_reg + 1'b1;
				cnt_next = cnt_reg + 1'b1;
				if (!ryby_s)
					rsp_next.busy_seen = 1'b1;
				if (cnt_reg >= CNT_W'(STROBE_CYC + 2)) begin
					cnt_next = '0;
					pins_next.oe_n = 1'b1;
					if (dq_s[DQ_POLL] == cur_reg.data[DQ_POLL] && ryby_s)
						st_next = ST_RECOVER; // reread word
					else if (dq_s[DQ_TIMEOUT] || poll_reg >= POLL_LIMIT)
						st_next = ST_RECOVER; // recheck once
				end
			end
			ST_RECOVER: begin
				pins_next.oe_n = 1'b0;
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg >= CNT_W'(STROBE_CYC + 2)) begin
					rsp_next.data = dq_s;
					rsp_next.timeout =
						dq_s[DQ_POLL] != cur_reg.data[DQ_POLL];
					pins_next.oe_n = 1'b1;
					pins_next.ce_n = 1'b1;
					st_next = ST_DONE;
				end
			end
			ST_DONE: begin
				rsp_valid_next = 1'b1;
				st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
	end

	assign req_ready = (st_reg == ST_IDLE);

	// registers; clock enable freezes everything
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			cur_reg <= '0;
			step_reg <= 3'h0;
			cnt_reg <= '0;
			poll_reg <= '0;
			pins <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1,
				we_n: 1'b1, oe_n: 1'b1};
			rsp <= '0;
			rsp_valid <= 1'b0;
		end else if (ce) begin
			st_reg <= st_next;
			cur_reg <= cur_next;
			step_reg <= step_next;
			cnt_reg <= cnt_next;
			poll_reg <= poll_next;
			pins <= pins_next;
			rsp <= rsp_next;
			rsp_valid <= rsp_valid_next;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_no_both_strobes: assert property (
		@(posedge mclk) disable iff (rst)
		!(!pins.we_n && !pins.oe_n))
		else $error("we and oe both low");
	a_drive_on_write: assert property (
		@(posedge mclk) disable iff (rst)
		!pins.we_n |-> pins.dq_oe && !pins.ce_n)
		else $error("write strobe without data drive");
	a_poll_after_wait: assert property (
		@(posedge mclk) disable iff (rst)
		(st_reg == ST_POLL) |-> poll_reg >= CNT_W'(STATUS_CYC - 1))
		else $error("status polled too early");
	a_read_no_drive: assert property (
		@(posedge mclk) disable iff (rst)
		!pins.oe_n |-> !pins.dq_oe)
		else $error("drive during read");
	a_addr_stable: assert property (
		@(posedge mclk) disable iff (rst || !ce)
		!pins.we_n && $past(!pins.we_n) |-> $stable(pins.addr))
		else $error("address moved in strobe");
	a_cmd_high_zero: assert property (
		@(posedge mclk) disable iff (rst)
		!pins.we_n && cur_reg.op == OP_RESET |->
		pins.dq_out[15:8] == 8'h00)
		else $error("command high byte nonzero");
endmodule : fcs_host

// ===== core/fcs_sync.sv
// Purpose: two-flop synchroniser for pins coming from the flash
// Assumes: sampled on mclk, frozen by the clock enable
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module fcs_sync #(
	parameter int W = 1
) (
	// clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s1_next;
	logic [W-1:0] q_next;
	// ---------------------------------------------------------------
	// stages
	// ---------------------------------------------------------------
	// next values: hold while the enable is low
	always_comb begin
		s1_next = ce ? d : s1_reg;
		q_next = ce ? s1_reg : q;
	end
	// registers only
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_reg <= '0;
			q <= '0;
		end else begin
			s1_reg <= s1_next;
			q <= q_next;
		end
	end
endmodule : fcs_sync

// ===== verif/fcs_flash_model.sv
// Purpose: behavioural flash that answers the host controller's bus cycles
// Assumes: only program, reset, exit and raw cycles are exercised
// Notes: stuck makes a program outside the protected sector e never finish so the timeout path is reached
`timescale 1ns/1ps
module fcs_flash_model
	import fcs_pkg::*;
#(
	parameter int T_PROG_NS = 6000,
	parameter int T_VALID_NS = 4000,
	parameter int T_GUARD_NS = 1000
) (
	// flash pins
	input wire fcs_pkg::fcs_pins_t pins,
	output logic [fcs_pkg::FCS_DW-1:0] dq_in,
	output logic ready_busy_n,
	// fault control
	input wire logic stuck
);
	logic [FCS_DW-1:0] mem [int];
	logic [FCS_DW-1:0] pdata, v, drv, last = 16'hffff;
	logic [FCS_AW-1:0] laddr, paddr;
	logic busy = 1'b0, early = 1'b0, failed = 1'b0;
	int step = 0;
	event go;
	wire wstb = pins.ce_n | pins.we_n;
	wire rstb = pins.ce_n | pins.oe_n;
	// -------------------------------------------------------------
	// command decode
	// -------------------------------------------------------------
	// address on the later falling edge of the two strobes
	always @(negedge wstb) laddr = pins.addr;
	// data on the first rising edge; upper byte, high address ignored
	always @(posedge wstb) begin
		if (step == 3) begin
			paddr = laddr;
			pdata = pins.dq_out;
			step = 0;
			->go;
		end else if (pins.dq_out[7:0] == CMD_RESET) begin
			busy = 1'b0; // reset leaves a failed program
			failed = 1'b0;
			step = 0;
		end else if (step == 0 && pins.dq_out[7:0] == DATA_UNLOCK1
			&& laddr[11:0] == ADDR_UNLOCK1[11:0])
			step = 1;
		else if (step == 1 && pins.dq_out[7:0] == DATA_UNLOCK2
			&& laddr[11:0] == ADDR_UNLOCK2[11:0])
			step = 2;
		else if (step == 2 && pins.dq_out[7:0] == CMD_PROGRAM)
			step = 3;
		else
			step = 0; // exit pair lands here, back to reads
	end
	// embedded program; early status is misleading on purpose
	// top address nibble e is a protected sector: short busy, no write
	always @(go) begin
		busy = 1'b1;
		if (paddr[FCS_AW-1 -: 4] == 4'he) begin
			#(T_GUARD_NS);
			busy = 1'b0;
		end else begin
			early = 1'b1;
			#(T_VALID_NS);
			early = 1'b0;
			if (stuck)
				failed = 1'b1;
			else begin
				#(T_PROG_NS - T_VALID_NS);
				mem[paddr] = pdata;
				busy = 1'b0;
			end
		end
	end
	// -------------------------------------------------------------
	// read path and ready pin
	// -------------------------------------------------------------
	// word the flash puts out while its outputs are enabled
	always @* begin
		v = ~pdata;
		v[DQ_POLL] = early ? pdata[DQ_POLL] : ~pdata[DQ_POLL];
		v[DQ_TIMEOUT] = failed;
		if (busy && pins.addr == paddr)
			drv = v;
		else
			drv = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
	end
	// kept apart from dq_in so the release edge cannot race the capture
	always @(posedge rstb) last = drv;
	// released bus shows the inverse of its last value, so a late
	// sample by the host reads visibly wrong data
	always @* dq_in = rstb ? ~last : drv;
	assign ready_busy_n = busy ? 1'b0 : 1'b1; // pull-up when idle
endmodule : fcs_flash_model

// ===== verif/fcs_host_tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: model program time 6 us, short poll limit
// Notes: random program data from a fixed seed plus corner words
`timescale 1ns/1ps
module fcs_host_tb_top;
	import fcs_pkg::*;
	localparam int POLL = 2000;
	logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0;
	logic stuck = 1'b0, req_ready, rsp_valid, ready_busy_n;
	fcs_req_t req = '0;
	fcs_rsp_t rsp;
	fcs_pins_t pins;
	logic [FCS_DW-1:0] dq_in, d;
	logic [FCS_AW-1:0] a;
	int n_errors = 0, comparisons = 0, cyc = 0, seed = 32'h00c14445;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
	always #2.5 mclk = ~mclk;
	fcs_host #(.POLL_LIMIT(POLL)) i_fcs_host (.mclk(mclk), .rst(rst),
		.ce(ce), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
		.dq_in(dq_in), .ready_busy_n(ready_busy_n));
	fcs_flash_model i_fcs_flash_model (.pins(pins), .dq_in(dq_in),
		.ready_busy_n(ready_busy_n), .stuck(stuck));
	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	// expected array word: new data if the write took, else erased ones
	function automatic logic [15:0] exp_word(input logic took,
		input logic [15:0] dt);
		return took ? dt : 16'hffff;
	endfunction : exp_word
	// one request, wait for its answer under a bound
	task automatic run_op(input fcs_op_t op, input logic [25:0] ad,
		input logic [15:0] dt);
		@(posedge mclk);
		req <= '{op, ad, dt};
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
		cyc = 0;
		do begin
			@(posedge mclk);
			#1;
			cyc++;
			if (cyc == 1)
				`CHK("busy ready", 1'b0, req_ready)
		end while (rsp_valid !== 1'b1 && cyc < 4 * POLL);
		`CHK("answer", 1'b1, rsp_valid)
		`CHK("idle ready", 1'b1, req_ready)
		`CHK("idle select", 1'b1, pins.ce_n)
	endtask : run_op
	// read and write strobes must never overlap
	always @(negedge mclk)
		if (!rst && !pins.we_n && !pins.oe_n)
			`CHK("strobes", 1'b1, pins.oe_n)
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		test_done();
	end
	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			a = {i[3:0], 22'($random(seed))};
			d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0080 :
				16'($random(seed));
			run_op(OP_PROGRAM, a, d);
			`CHK("no early finish", 1'b1, cyc > 1000)
			`CHK("prog timeout", 1'b0, rsp.timeout)
			`CHK("busy seen", 1'b1, rsp.busy_seen)
			run_op(OP_READ, a, 16'h0000);
			`CHK("readback", exp_word(1'b1, d), rsp.data)
		end
		$display("test program done");
		stuck <= 1'b1;
		a = {4'hf, 22'($random(seed))};
		run_op(OP_PROGRAM, a, 16'h1234);
		`CHK("stuck timeout", 1'b1, rsp.timeout)
		stuck <= 1'b0;
		run_op(OP_RESET, 26'h0, 16'h0000);
		`CHK("ready after reset", 1'b1, ready_busy_n)
		run_op(OP_READ, a, 16'h0000);
		`CHK("failed word", exp_word(1'b0, 16'h1234), rsp.data)
		// protected sector: polling bit never matches, host gives up
		a = {4'he, 22'($random(seed))};
		run_op(OP_PROGRAM, a, 16'h0000);
		`CHK("protected timeout", 1'b1, rsp.timeout)
		`CHK("protected busy", 1'b1, rsp.busy_seen)
		run_op(OP_READ, a, 16'h0000);
		`CHK("protected word", exp_word(1'b0, 16'h0000), rsp.data)
		$display("test timeout done");
		run_op(OP_EXIT, 26'h0, 16'h0000);
		run_op(OP_WRITE, 26'h3fffaaa, 16'hfff0);
		`CHK("write idle", 1'b0, pins.dq_oe)
		$display("test raw done");
		test_done();
	end
endmodule : fcs_host_tb_top
